// >>> rtl/sac_pkg.sv
// shared constants and types of the converter control unit
package sac_pkg;
  // register indices and their byte addresses on the bus
  localparam int          SAC_ADDR_W    = 10;
  localparam logic [7:0]  SAC_CSR_IDX   = 8'h70;
  localparam logic [7:0]  SAC_HIGH_IDX  = 8'h71;
  localparam logic [7:0]  SAC_LOW_IDX   = 8'h72;
  localparam logic [9:0]  SAC_CSR_ADDR  = {SAC_CSR_IDX, 2'h0};
  localparam logic [9:0]  SAC_HIGH_ADDR = {SAC_HIGH_IDX, 2'h0};
  localparam logic [9:0]  SAC_LOW_ADDR  = {SAC_LOW_IDX, 2'h0};
  // control/status field positions and reset value
  localparam int          SAC_EOC_BIT   = 7;
  localparam int          SAC_SPEED_BIT = 6;
  localparam int          SAC_ON_BIT    = 5;
  localparam int          SAC_CH_LSB    = 0;
  localparam int          SAC_CH_W      = 4;
  localparam logic [7:0]  SAC_CSR_RESET = 8'h00;
  // result layout
  localparam int          SAC_RES_W     = 10;
  localparam logic [9:0]  SAC_RES_RESET = 10'h000;
  localparam logic [9:0]  SAC_RES_FULL  = 10'h3FF;
  localparam logic [3:0]  SAC_MSB_IDX   = 4'h9;
  // converter clock dividers: last count of /4 and /2
  localparam logic [1:0]  SAC_DIV4_LAST = 2'h3;
  localparam logic [1:0]  SAC_DIV2_LAST = 2'h1;
  // sequencer states
  typedef enum logic [1:0] {SQ_IDLE, SQ_SAMPLE, SQ_BITS} sac_seq_state_t;
endpackage : sac_pkg

// >>> rtl/sac_clk_div.sv
// converter clock divider, one step pulse per converter clock
`timescale 1ns/1ps
module sac_clk_div (
  input  wire logic clk,     // cpu clock
  input  wire logic reset_n, // async reset, active low
  input  wire logic run,     // converter running
  input  wire logic fast,    // 1: divide by 2, 0: divide by 4
  output logic      step,    // one-cycle step pulse
  output logic      adc_clk  // divided converter clock
);
  import sac_pkg::*;

  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic       next_adc_clk;
  logic [1:0] last;

  ////////////////////////////////////////////////////////////////
  // divide by 4 or by 2 as the speed bit asks
  always_comb begin
    last         = fast ? SAC_DIV2_LAST : SAC_DIV4_LAST;
    step         = run && (cnt == last);
    next_cnt     = (!run || step) ? 2'h0 : cnt + 2'h1;
    next_adc_clk = run && (fast ? next_cnt[0] : next_cnt[1]);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt     <= 2'h0;
      adc_clk <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      adc_clk <= next_adc_clk;
    end
  end

  ////////////////////////////////////////////////////////////////
  // step spacing checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_fast_run;
    step && fast && run ##1 (fast && run) [*2];
  endsequence
  sequence s_slow_run;
    step && !fast && run ##1 (!fast && run && !step) [*3] ##1 (!fast && run);
  endsequence

  chk_div_two: assert property (s_fast_run |-> step)
    else $error("fast divider missed its step");
  chk_div_four: assert property (s_slow_run |-> step)
    else $error("slow divider missed its step");
endmodule : sac_clk_div

// >>> rtl/sac_sar_seq.sv
// successive-approximation sequencer, sample then ten bit decisions
`timescale 1ns/1ps
module sac_sar_seq (
  input  wire logic                            clk,           // cpu clock
  input  wire logic                            reset_n,       // async reset, active low
  input  wire logic                            run,           // converter running
  input  wire logic                            restart,       // abort and resample
  input  wire logic                            step,          // converter clock step
  input  wire logic                            comp_high,     // input above trial code
  output logic                                 sample_hold,   // sample phase
  output logic [sac_pkg::SAC_RES_W-1:0]        trial,         // code under test
  output logic                                 done,          // one-cycle end pulse
  output logic [sac_pkg::SAC_RES_W-1:0]        result         // finished code
);
  import sac_pkg::*;

  sac_seq_state_t         state;
  sac_seq_state_t         next_state;
  logic [3:0]             bit_idx;
  logic [3:0]             next_bit_idx;
  logic [SAC_RES_W-1:0]   next_trial;
  logic                   next_done;
  logic [SAC_RES_W-1:0]   next_result;

  ////////////////////////////////////////////////////////////////
  // bit decisions, most significant first, restart after each result
  always_comb begin
    next_state   = state;
    next_bit_idx = bit_idx;
    next_trial   = trial;
    next_done    = 1'b0;
    next_result  = result;
    if (!run) begin
      next_state = SQ_IDLE;
      next_trial = SAC_RES_RESET;
    end else if (restart) begin
      next_state = SQ_SAMPLE;
      next_trial = SAC_RES_RESET;
    end else begin
      unique case (state)
        SQ_IDLE: next_state = SQ_SAMPLE;
        SQ_SAMPLE: if (step) begin
          next_state   = SQ_BITS;
          next_bit_idx = SAC_MSB_IDX;
          next_trial   = SAC_RES_RESET;
          next_trial[SAC_MSB_IDX] = 1'b1;
        end
        SQ_BITS: if (step) begin
          next_trial[bit_idx] = comp_high;
          if (bit_idx == 4'h0) begin
            next_done   = 1'b1;
            next_result = next_trial;
            next_state  = SQ_SAMPLE;
          end else begin
            next_bit_idx = bit_idx - 4'h1;
            next_trial[bit_idx - 4'h1] = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state   <= SQ_IDLE;
      bit_idx <= 4'h0;
      trial   <= SAC_RES_RESET;
      done    <= 1'b0;
      result  <= SAC_RES_RESET;
    end else begin
      state   <= next_state;
      bit_idx <= next_bit_idx;
      trial   <= next_trial;
      done    <= next_done;
      result  <= next_result;
    end
  end

  assign sample_hold = (state == SQ_SAMPLE);

  ////////////////////////////////////////////////////////////////
  // helper: any low or high decision seen in this conversion
  logic saw_low;
  logic saw_high;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      saw_low  <= 1'b0;
      saw_high <= 1'b0;
    end else if (state != SQ_BITS) begin
      saw_low  <= 1'b0;
      saw_high <= 1'b0;
    end else if (step) begin
      saw_low  <= saw_low | !comp_high;
      saw_high <= saw_high | comp_high;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_full_scale: assert property (done && !saw_low |-> result == SAC_RES_FULL)
    else $error("input above reference did not give full scale");
  chk_zero_scale: assert property (done && !saw_high |-> result == SAC_RES_RESET)
    else $error("input below reference did not give zero");
endmodule : sac_sar_seq

// >>> rtl/sac_adc_ctrl.sv
// control, status and result registers of the converter on avalon-mm
//
// Overview of operation
// - input above high reference gives all ones result, no overflow flag
// - input below low reference gives a zero result in both data registers
// - setting converter_on enables converter; it then converts the channel continuously
// - each finished conversion sets the end flag and updates the data registers
// - end flag clears on a high data read or any control/status write
// - results are not latched; each conversion overwrites both data registers
// - new channel bits during conversion abort it, clear flag, restart
// - converter clock is cpu clock over 4, or over 2 when speed set
// - clearing converter_on disables converter and stops the conversion
// - channel bits map straight to analog input numbers 0 to 15
// - high data register returns result bits 9 to 2
// - low data register returns result bits 1 and 0, upper bits zero
// - end flag read-only, reserved bit 4 reads zero, rest read/write; register resets to zero
// - processor wait mode leaves converter operation untouched
// - halt mode disables converter; software waits to settle after wake
// - the converter raises no interrupt; completion is seen by polling
`timescale 1ns/1ps
module sac_adc_ctrl (
  input  wire logic                            clk,              // cpu clock, 250 MHz
  input  wire logic                            reset_n,          // async reset, active low
  input  wire logic [sac_pkg::SAC_ADDR_W-1:0]  address,          // byte address
  input  wire logic                            read,             // read request
  input  wire logic                            write,            // write request
  input  wire logic [31:0]                     writedata,        // write data
  input  wire logic [3:0]                      byteenable,       // byte lanes
  output logic [31:0]                          readdata,         // read data
  output logic                                 waitrequest,      // stall request
  input  wire logic                            halt_mode,        // processor in halt
  input  wire logic                            comparator_high,  // input above trial code
  output logic                                 converter_enable, // analog power on
  output logic                                 adc_clk,          // converter clock
  output logic [sac_pkg::SAC_CH_W-1:0]         channel_select,   // analog mux select
  output logic                                 sample_hold,      // sampling phase
  output logic [sac_pkg::SAC_RES_W-1:0]        sar_trial         // trial code to dac
);
  import sac_pkg::*;

  ////////////////////////////////////////////////////////////////
  // state
  logic                   ack;
  logic                   next_ack;
  logic [31:0]            next_readdata;
  logic                   speed;
  logic                   next_speed;
  logic                   conv_on;
  logic                   next_conv_on;
  logic [SAC_CH_W-1:0]    next_channel;
  logic                   eoc;
  logic                   next_eoc;
  logic [SAC_RES_W-1:0]   result;
  logic [SAC_RES_W-1:0]   next_result;
  logic                   next_enable;

  // decode and accepted accesses
  logic                   sel_csr;
  logic                   sel_high;
  logic                   sel_low;
  logic                   wr_csr;
  logic                   rd_high;
  logic                   chan_change;
  logic                   abort;
  logic                   run;
  logic [7:0]             csr_view;

  // sequencer and divider wiring
  logic                   step;
  logic                   seq_done;
  logic [SAC_RES_W-1:0]   seq_result;

  ////////////////////////////////////////////////////////////////
  // bus decode: one wait cycle, then the access is accepted
  assign sel_csr     = (address == SAC_CSR_ADDR);
  assign sel_high    = (address == SAC_HIGH_ADDR);
  assign sel_low     = (address == SAC_LOW_ADDR);
  assign waitrequest = (read || write) && !ack;
  assign wr_csr      = write && ack && byteenable[0] && sel_csr;
  assign rd_high     = read && ack && sel_high;
  // wait mode has no input here, so it cannot touch the converter
  assign run         = conv_on && !halt_mode;
  assign chan_change = writedata[SAC_CH_LSB +: SAC_CH_W] != channel_select;
  assign abort       = wr_csr && run && chan_change;
  // reserved bit 4 always reads zero
  assign csr_view    = {eoc, speed, conv_on, 1'b0, channel_select};

  ////////////////////////////////////////////////////////////////
  // bus handshake and read data capture
  always_comb begin
    next_ack      = (read || write) && !ack;
    next_readdata = readdata;
    if (read && !ack) begin
      next_readdata = 32'h0000_0000;
      unique case (1'b1)
        sel_csr:  next_readdata[7:0] = csr_view;
        sel_high: next_readdata[7:0] = result[SAC_RES_W-1:2];
        sel_low:  next_readdata[1:0] = result[1:0];
        default:  next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack      <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      ack      <= next_ack;
      readdata <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  // control/status register, end flag and data registers
  always_comb begin
    next_speed   = speed;
    next_conv_on = conv_on;
    next_channel = channel_select;
    next_eoc     = eoc;
    next_result  = result;
    if (wr_csr) begin
      next_speed   = writedata[SAC_SPEED_BIT];
      next_conv_on = writedata[SAC_ON_BIT];
      next_channel = writedata[SAC_CH_LSB +: SAC_CH_W];
    end
    if (wr_csr || rd_high) begin
      next_eoc = 1'b0;
    end
    // a finishing conversion wins over a clear in the same cycle
    if (seq_done) begin
      next_eoc    = 1'b1;
      next_result = seq_result;
    end
    next_enable = run;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      speed            <= SAC_CSR_RESET[SAC_SPEED_BIT];
      conv_on          <= SAC_CSR_RESET[SAC_ON_BIT];
      channel_select   <= SAC_CSR_RESET[SAC_CH_LSB +: SAC_CH_W];
      eoc              <= SAC_CSR_RESET[SAC_EOC_BIT];
      result           <= SAC_RES_RESET;
      converter_enable <= 1'b0;
    end else begin
      speed            <= next_speed;
      conv_on          <= next_conv_on;
      channel_select   <= next_channel;
      eoc              <= next_eoc;
      result           <= next_result;
      converter_enable <= next_enable;
    end
  end

  ////////////////////////////////////////////////////////////////
  // converter clock and bit sequencer; no interrupt output exists
  sac_clk_div u_div (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (run),
    .fast    (speed),
    .step    (step),
    .adc_clk (adc_clk)
  );

  // completion only shows in the end flag, polled by software
  sac_sar_seq u_seq (
    .clk         (clk),
    .reset_n     (reset_n),
    .run         (run),
    .restart     (abort),
    .step        (step),
    .comp_high   (comparator_high),
    .sample_hold (sample_hold),
    .trial       (sar_trial),
    .done        (seq_done),
    .result      (seq_result)
  );

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // an accepted read of one register
  sequence s_rd_accept(logic sel);
    read && ack && sel;
  endsequence

  // an accepted read with no result load since its data was captured
  sequence s_rd_clean(logic sel);
    s_rd_accept(sel) ##0 !$past(seq_done);
  endsequence

  // the conversion under way ends, stops or restarts
  sequence s_conv_end;
    seq_done || !run || abort;
  endsequence

  // a finished conversion raises the end flag
  chk_eoc_on_done: assert property (seq_done |=> eoc)
    else $error("end flag not set after conversion");

  // both data registers take the new result
  chk_result_load: assert property (seq_done |=> result == $past(seq_result))
    else $error("data registers not overwritten by new result");

  // a high data read clears the flag
  chk_eoc_rd_clear: assert property (rd_high && !seq_done |=> !eoc)
    else $error("high data read did not clear end flag");

  // a control write clears the flag
  chk_eoc_wr_clear: assert property (wr_csr && !seq_done |=> !eoc)
    else $error("control write did not clear end flag");

  // a channel change restarts at the sample phase
  chk_abort_restart: assert property (abort && !halt_mode && writedata[SAC_ON_BIT]
    |=> sample_hold && sar_trial == SAC_RES_RESET)
    else $error("channel change did not restart conversion");

  // nothing samples or converts while off
  chk_off_stops: assert property (!conv_on |=> !sample_hold && sar_trial == SAC_RES_RESET)
    else $error("converter kept running while off");

  // halt powers the converter down at once
  chk_halt_disable: assert property (halt_mode |=> !converter_enable && !sample_hold)
    else $error("halt did not disable converter");

  // high data read returns result bits 9 to 2
  chk_high_map: assert property (s_rd_clean(sel_high) |-> readdata[7:0] == result[SAC_RES_W-1:2])
    else $error("high data register mapping wrong");

  // low data register upper bits read zero
  chk_low_zero: assert property (s_rd_accept(sel_low) |-> readdata[31:2] == 30'h0)
    else $error("low data register upper bits not zero");

  // reserved control bit reads zero
  chk_csr_rsv: assert property (s_rd_accept(sel_csr) |-> readdata[4] == 1'b0)
    else $error("reserved control bit read as one");

  // one wait cycle per access
  chk_wait_len: assert property ((read || write) && !ack |=> !waitrequest)
    else $error("bus access not answered after one wait cycle");

  // low data read returns result bits 1 and 0
  chk_low_map: assert property (s_rd_clean(sel_low) |-> readdata[1:0] == result[1:0])
    else $error("low data register mapping wrong");

  // high data register holds nothing above bit 7
  chk_high_upper: assert property (s_rd_accept(sel_high) |-> readdata[31:8] == 24'h0)
    else $error("high data register upper bits not zero");

  // control read shows the stored fields
  chk_csr_fields: assert property (s_rd_accept(sel_csr)
    |-> readdata[6:0] == {speed, conv_on, 1'b0, channel_select})
    else $error("control fields read back wrong");

  // a control write loads its fields
  chk_wr_fields: assert property (wr_csr |=> speed == $past(writedata[SAC_SPEED_BIT])
    && conv_on == $past(writedata[SAC_ON_BIT])
    && channel_select == $past(writedata[SAC_CH_LSB +: SAC_CH_W]))
    else $error("control write did not load its fields");

  // control fields hold without a write
  chk_csr_hold: assert property (!wr_csr |=> $stable({speed, conv_on, channel_select}))
    else $error("control fields changed without a write");

  // the end flag moves only on a result, a high read or a control write
  chk_eoc_hold: assert property (!seq_done && !wr_csr && !rd_high |=> eoc == $past(eoc))
    else $error("end flag changed without cause");

  // data registers change only on a result
  chk_result_hold: assert property (!seq_done |=> $stable(result))
    else $error("data registers changed without a result");

  // converter power follows the run condition
  chk_enable_run: assert property (conv_on && !halt_mode |=> converter_enable)
    else $error("converter not enabled while on");

  // every conversion ends within eleven slow steps
  chk_conv_time: assert property ($rose(sample_hold) |-> ##[1:46] s_conv_end)
    else $error("conversion took too long");

  // the first trial after sampling tests the top bit alone
  chk_msb_first: assert property (sample_hold && step && run && !abort |=> $onehot(sar_trial) && sar_trial[SAC_RES_W-1])
    else $error("first trial was not the top bit");

  // no conversion completes while stopped
  chk_no_done_off: assert property (!run |=> !seq_done)
    else $error("conversion finished while stopped");

  // converter clock rests low while stopped
  chk_clk_idle: assert property (!run |=> !adc_clk)
    else $error("converter clock ran while stopped");

  // an abort clears the flag unless a result lands with it
  chk_abort_clear: assert property (abort && !seq_done |=> !eoc)
    else $error("channel change did not clear end flag");
endmodule : sac_adc_ctrl

// >>> bench/sac_analog_model.sv
// analog front end model: selected input level compared with the trial code
`timescale 1ns/1ps
module sac_analog_model (
  input  wire logic        clk,        // cpu clock
  input  wire logic        powered,    // converter enabled
  input  wire logic [3:0]  channel,    // selected analog input
  input  wire logic [9:0]  trial,      // trial code from the dac
  input  wire logic [10:0] level [16], // input levels, 400h and up lies above the high reference
  output logic             above       // comparator output
);
  logic flip; // unpowered comparator gives no steady answer
  initial flip = 1'b0;
  always @(posedge clk) flip <= ~flip;
  // comparator judges the input chosen by the channel bits
  always_comb above = powered ? (level[channel] > {1'b0, trial}) : flip;
endmodule : sac_analog_model

// >>> bench/test_sac_adc_ctrl.sv
// self-checking bench of the converter control unit
`timescale 1ns/1ps
module test_sac_adc_ctrl;
  import sac_pkg::*;
  logic        clk, reset_n, read, write, halt_mode, comparator_high;
  logic        waitrequest, converter_enable, adc_clk, sample_hold;
  logic [9:0]  address, sar_trial;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable, channel_select;
  logic [10:0] level [16];
  int          fails, check_count;

  sac_adc_ctrl u_sac_adc_ctrl (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .halt_mode(halt_mode), .comparator_high(comparator_high),
    .converter_enable(converter_enable), .adc_clk(adc_clk), .channel_select(channel_select),
    .sample_hold(sample_hold), .sar_trial(sar_trial));
  sac_analog_model u_sac_analog_model (.clk(clk), .powered(converter_enable),
    .channel(channel_select), .trial(sar_trial), .level(level), .above(comparator_high));

  ////////////////////////////////////////////////////////////////////////////
  // clock and checking helpers
  always #2 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // one bus cycle, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] wd, output logic [7:0] rd);
    address   <= a;
    writedata <= {24'h000000, wd};
    read      <= !wr;
    write     <= wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rd = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus

  // code expected from an input level
  function automatic logic [9:0] exp_code(input logic [10:0] lv);
    return (lv > 11'h3FF) ? 10'h3FF : ((lv == 11'h000) ? 10'h000 : lv[9:0] - 10'h001);
  endfunction : exp_code

  task automatic wait_eoc();
    logic [7:0] d;
    int         n;
    n = 0;
    do begin
      bus(1'b0, SAC_CSR_ADDR, 8'h00, d);
      n++;
    end while (d[7] !== 1'b1 && n < 100);
    check(d[7], 1'b1, "end flag set");
  endtask : wait_eoc

  task automatic get_result(output logic [9:0] r);
    logic [7:0] lo, hi;
    bus(1'b0, SAC_LOW_ADDR, 8'h00, lo);
    bus(1'b0, SAC_HIGH_ADDR, 8'h00, hi);
    check(lo[7:2], 6'h00, "low register upper bits");
    r = {hi, lo[1:0]};
  endtask : get_result

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    logic [7:0] d;
    bus(1'b0, SAC_CSR_ADDR, 8'h00, d);
    check(d, SAC_CSR_RESET, "control after reset");
    bus(1'b0, SAC_HIGH_ADDR, 8'h00, d);
    check(d, 8'h00, "high after reset");
    bus(1'b0, SAC_LOW_ADDR, 8'h00, d);
    check(d, 8'h00, "low after reset");
    bus(1'b0, 10'h3FC, 8'h00, d);
    check(d, 8'h00, "unmapped read");
    check(converter_enable, 1'b0, "converter off after reset");
  endtask : t_reset

  // start a channel, check the converter clock rate and the result
  task automatic t_convert(input logic [3:0] ch, input logic spd);
    logic [7:0] d;
    logic [9:0] r;
    logic       prev;
    int         rises;
    bus(1'b1, SAC_CSR_ADDR, {1'b1, spd, 1'b1, 1'b0, ch}, d);
    check(channel_select, ch, "channel pins");
    rises = 0;
    repeat (4) @(posedge clk);
    prev = adc_clk;
    repeat (16) begin
      @(negedge clk);
      if (adc_clk === 1'b1 && prev === 1'b0) rises++;
      prev = adc_clk;
    end
    @(posedge clk);
    check(rises, spd ? 8 : 4, "converter clock rate");
    wait_eoc();
    get_result(r);
    check(r, exp_code(level[ch]), "conversion result");
    bus(1'b0, SAC_CSR_ADDR, 8'h00, d);
    check(d, {1'b0, spd, 2'b10, ch}, "control after high read");
  endtask : t_convert

  // repeated conversions, clear by write, no latching of the result
  task automatic t_continuous();
    logic [7:0] d;
    logic [9:0] r;
    wait_eoc();
    bus(1'b1, SAC_CSR_ADDR, 8'h23, d);
    bus(1'b0, SAC_CSR_ADDR, 8'h00, d);
    check(d[7], 1'b0, "flag cleared by write");
    wait_eoc();
    bus(1'b0, SAC_HIGH_ADDR, 8'h00, d);
    check(d, exp_code(11'h2B6) >> 2, "eight-bit read");
    bus(1'b0, SAC_CSR_ADDR, 8'h00, d);
    check(d[7], 1'b0, "flag cleared by high read");
    level[3] <= 11'h1E9;
    repeat (2) begin
      bus(1'b1, SAC_CSR_ADDR, 8'h23, d);
      wait_eoc();
    end
    get_result(r);
    check(r, exp_code(11'h1E9), "result overwritten");
  endtask : t_continuous

  // change channel mid-conversion
  task automatic t_switch();
    logic [7:0] d;
    logic [9:0] r;
    get_result(r);
    repeat (12) @(posedge clk);
    bus(1'b1, SAC_CSR_ADDR, 8'h25, d);
    bus(1'b0, SAC_CSR_ADDR, 8'h00, d);
    check(d, 8'h25, "flag cleared on channel change");
    wait_eoc();
    get_result(r);
    check(r, exp_code(level[5]), "new channel converted whole");
  endtask : t_switch

  // converter off, then halt mode
  task automatic t_off();
    logic [7:0] d;
    bus(1'b1, SAC_CSR_ADDR, 8'h05, d);
    @(posedge clk);
    check(converter_enable, 1'b0, "converter disabled");
    repeat (120) @(posedge clk);
    bus(1'b0, SAC_CSR_ADDR, 8'h00, d);
    check(d, 8'h05, "no conversion while off");
    bus(1'b1, SAC_CSR_ADDR, 8'h25, d);
    halt_mode <= 1'b1;
    repeat (3) @(posedge clk);
    check(converter_enable, 1'b0, "disabled in halt");
    bus(1'b1, SAC_CSR_ADDR, 8'h25, d);
    repeat (120) @(posedge clk);
    bus(1'b0, SAC_CSR_ADDR, 8'h00, d);
    check(d, 8'h25, "no conversion in halt");
    halt_mode <= 1'b0;
    @(posedge clk);
    wait_eoc();
  endtask : t_off

  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 10'h000;
    writedata = 32'h00000000;
    byteenable = 4'hF;
    halt_mode = 1'b0;
    fails = 0;
    check_count = 0;
    foreach (level[i]) level[i] = 11'h155;
    level[0] = 11'h000;
    level[15] = 11'h7FF;
    level[3] = 11'h2B6;
    level[5] = 11'h0C4;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_convert(4'h0, 1'b0);
    t_convert(4'hF, 1'b1);
    t_convert(4'h3, 1'b0);
    t_continuous();
    t_switch();
    t_off();
    summarize();
  end

  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule : test_sac_adc_ctrl
